// *** logic/adcsq_defs.svh ***
// Purpose: Constants for the converter sequence control block.
// Assumes: Core clock of 250 MHz; one E cycle is one core clock cycle.
// Notes:   Times are counted in E cycles.
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH

`define ADCSQ_CONV_CYCLES   6'h20
`define ADCSQ_SAMPLE_CYCLES 6'h0C
`define ADCSQ_BIT_START     6'h18
`define ADCSQ_SLOTS         3'h4
`define ADCSQ_CODE_ZERO     8'h00
`define ADCSQ_CODE_FULL     8'hFF
`define ADCSQ_CODE_HALF     8'h80
`define ADCSQ_CH_REF_HIGH   4'hC
`define ADCSQ_CH_REF_LOW    4'hD
`define ADCSQ_CH_REF_HALF   4'hE
`define ADCSQ_CH_LAST_INPUT 4'h7

`endif

// *** logic/adcsq_pkg.sv ***
// Purpose: Types for the converter sequence control block.
// Assumes: Constants come from adcsq_defs.svh.
// Notes:   None.
package adcsq_pkg;

    typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_SAMPLE, ADCSQ_APPROX} adcsq_state_t;

    typedef struct packed {
        logic [3:0] channel;
        logic       scan;
    } adcsq_cmd_t;

    typedef struct packed {
        logic       wr_en;
        logic [1:0] wr_slot;
        logic [7:0] wr_data;
    } adcsq_wr_t;

    typedef struct packed {
        adcsq_state_t state;
        adcsq_cmd_t   cmd;
        logic         start;
        logic [5:0]   cnt;
        logic [1:0]   slot;
        logic [2:0]   done_cnt;
        logic [7:0]   sar;
        logic [7:0]   trial;
        logic [7:0]   sample;
        adcsq_wr_t    wr;
        logic         busy;
        logic [2:0]   done_pulse;
    } adcsq_ctl_t;

endpackage

// *** logic/adcsq_result_mem.sv ***
// Purpose: Four read-only result slots of the converter.
// Assumes: Written only by the sequencer at conversion completion.
// Notes:   Read data come out of a register.
`timescale 1ns/10ps
module adcsq_result_mem
    import adcsq_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    // Write from sequencer
    input  wire adcsq_wr_t  wr_i,
    // Read port
    input  wire logic [1:0] rd_slot_i,
    output logic [7:0]      rd_data_o
);

    typedef struct packed {
        logic [3:0][7:0] slot;
        logic [7:0]      rd;
    } adcsq_mem_t;

    adcsq_mem_t mem_reg;
    adcsq_mem_t mem_next;

    always_comb begin
        mem_next = mem_reg;
        if (wr_i.wr_en) begin
            mem_next.slot[wr_i.wr_slot] = wr_i.wr_data;
        end
        mem_next.rd = mem_reg.slot[rd_slot_i];
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            mem_reg <= '0;
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign rd_data_o = mem_reg.rd;

endmodule // adcsq_result_mem

// *** logic/adcsq_seq.sv ***
// Purpose: Sequencer of an 8-bit successive-approximation converter.
// Assumes: Analog levels arrive as 8-bit digitised codes from outside the clock domain.
// Notes:   Each conversion is 12 sample cycles then 20 approximation cycles.
`timescale 1ns/10ps
`include "adcsq_defs.svh"
module adcsq_seq
    import adcsq_pkg::*;
(
    // Clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            rst_b_i,
    // Command write
    input  wire logic            cmd_wr_i,
    input  wire adcsq_cmd_t      cmd_i,
    // Analog inputs and references as codes
    input  wire logic [7:0][7:0] analog_in_i,
    input  wire logic [7:0]      ref_high_i,
    input  wire logic [7:0]      ref_low_i,
    // Result read
    input  wire logic [1:0]      rd_slot_i,
    output logic [7:0]           rd_data_o,
    // Status
    output logic                 busy_o,
    output logic [2:0]           done_count_o,
    output logic                 conv_done_o
);

    adcsq_ctl_t       ctl_reg;
    adcsq_ctl_t       ctl_next;
    logic [7:0][7:0]  ain_meta_reg;
    logic [7:0][7:0]  ain_sync_reg;
    logic [7:0]       rh_meta_reg;
    logic [7:0]       rh_sync_reg;
    logic [7:0]       rl_meta_reg;
    logic [7:0]       rl_sync_reg;
    logic [7:0]       level;

    // --------------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ain_meta_reg <= '0;
            ain_sync_reg <= '0;
            rh_meta_reg  <= '0;
            rh_sync_reg  <= '0;
            rl_meta_reg  <= '0;
            rl_sync_reg  <= '0;
        end else begin
            ain_meta_reg <= analog_in_i;
            ain_sync_reg <= ain_meta_reg;
            rh_meta_reg  <= ref_high_i;
            rh_sync_reg  <= rh_meta_reg;
            rl_meta_reg  <= ref_low_i;
            rl_sync_reg  <= rl_meta_reg;
        end
    end

    // Maps a level between the references onto 00 to FF without overflow.
    function automatic logic [7:0] scale(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        logic [15:0] num;
        logic [7:0]  span;
        num  = '0;
        span = hi - lo;
        if (v <= lo || span == `ADCSQ_CODE_ZERO) begin
            scale = `ADCSQ_CODE_ZERO;
        end else if (v >= hi) begin
            scale = `ADCSQ_CODE_FULL;
        end else begin
            num   = {8'h00, 8'(v - lo)} * {8'h00, `ADCSQ_CODE_FULL};
            scale = 8'(num / {8'h00, span});
        end
    endfunction

    // --------------------------------------------------------------------
    // Channel multiplexer
    // --------------------------------------------------------------------
    always_comb begin
        level = rl_sync_reg;
        if (ctl_reg.cmd.channel <= `ADCSQ_CH_LAST_INPUT) begin
            level = ain_sync_reg[ctl_reg.cmd.channel[2:0]];
        end else if (ctl_reg.cmd.channel == `ADCSQ_CH_REF_HIGH) begin
            level = rh_sync_reg;
        end else if (ctl_reg.cmd.channel == `ADCSQ_CH_REF_HALF) begin
            level = 8'(rl_sync_reg + ((rh_sync_reg - rl_sync_reg) >> 1));
        end
    end

    // --------------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------------
    always_comb begin
        ctl_next            = ctl_reg;
        ctl_next.wr         = '0;
        ctl_next.start      = 1'b0;
        ctl_next.done_pulse = 3'h0;
        unique case (ctl_reg.state)
            ADCSQ_IDLE: begin
                if (ctl_reg.start) begin
                    ctl_next.state = ADCSQ_SAMPLE;
                    ctl_next.cnt   = 6'h01;
                end
            end
            ADCSQ_SAMPLE: begin
                ctl_next.sample = scale(level, rl_sync_reg, rh_sync_reg);
                ctl_next.cnt    = ctl_reg.cnt + 6'h01;
                if (ctl_reg.cnt == `ADCSQ_SAMPLE_CYCLES) begin
                    ctl_next.state = ADCSQ_APPROX;
                    ctl_next.sar   = `ADCSQ_CODE_ZERO;
                    ctl_next.trial = `ADCSQ_CODE_HALF;
                end
            end
            ADCSQ_APPROX: begin
                ctl_next.cnt = ctl_reg.cnt + 6'h01;
                // All eight trials finish before the last cycle, so the written code holds the final bit.
                if (ctl_reg.cnt >= `ADCSQ_BIT_START && ctl_reg.trial != `ADCSQ_CODE_ZERO) begin
                    if ((ctl_reg.sar | ctl_reg.trial) <= ctl_reg.sample) begin
                        ctl_next.sar = ctl_reg.sar | ctl_reg.trial;
                    end
                    ctl_next.trial = ctl_reg.trial >> 1;
                end
                if (ctl_reg.cnt == `ADCSQ_CONV_CYCLES) begin
                    ctl_next.wr.wr_en   = 1'b1;
                    ctl_next.wr.wr_slot = ctl_reg.slot;
                    ctl_next.wr.wr_data = ctl_reg.sar;
                    ctl_next.slot       = ctl_reg.slot + 2'h1;
                    ctl_next.done_pulse = 3'h1;
                    ctl_next.cnt        = 6'h01;
                    if (ctl_reg.done_cnt != `ADCSQ_SLOTS) begin
                        ctl_next.done_cnt = ctl_reg.done_cnt + 3'h1;
                    end
                    if (!ctl_reg.cmd.scan && ctl_reg.slot == 2'h3) begin
                        ctl_next.state = ADCSQ_IDLE;
                        ctl_next.busy  = 1'b0;
                    end else begin
                        ctl_next.state = ADCSQ_SAMPLE;
                    end
                end
            end
        endcase
        if (cmd_wr_i) begin
            ctl_next.cmd      = cmd_i;
            ctl_next.state    = ADCSQ_IDLE;
            ctl_next.start    = 1'b1;
            ctl_next.busy     = 1'b1;
            ctl_next.slot     = 2'h0;
            ctl_next.done_cnt   = 3'h0;
            ctl_next.wr         = '0;
            ctl_next.done_pulse = 3'h0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ctl_reg <= '{state: ADCSQ_IDLE, default: '0};
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    adcsq_result_mem u_mem (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .wr_i       (ctl_reg.wr),
        .rd_slot_i  (rd_slot_i),
        .rd_data_o  (rd_data_o)
    );

    assign busy_o       = ctl_reg.busy;
    assign done_count_o = ctl_reg.done_cnt;
    assign conv_done_o  = ctl_reg.done_pulse[0];

endmodule // adcsq_seq

// *** verification/adcsq_seq_monitor.sv ***
// Purpose: Port timing checks of the converter sequencer.
// Assumes: One E cycle per clock.
// Notes:   Bound to adcsq_seq.
`timescale 1ns/10ps
module adcsq_seq_monitor
    import adcsq_pkg::*;
(
    // Design ports
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    input wire logic       cmd_wr_i,
    input wire adcsq_cmd_t cmd_i,
    input wire logic [1:0] rd_slot_i,
    input wire logic [7:0] rd_data_o,
    input wire logic       busy_o,
    input wire logic [2:0] done_count_o,
    input wire logic       conv_done_o
);
    // Cycles since the last command write.
    logic [15:0] since_reg;
    logic        scan_reg;
    logic        run;
    logic        exp_done;
    logic        exp_busy;
    logic [2:0]  exp_cnt;
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            since_reg <= 16'h0000;
            scan_reg  <= 1'b0;
        end else if (cmd_wr_i) begin
            since_reg <= 16'h0001;
            scan_reg  <= cmd_i.scan;
        end else if (since_reg != 16'h0000) begin
            since_reg <= since_reg + 16'h0001;
        end
    end
    assign run      = (since_reg >= 16'h0022) && (scan_reg || since_reg <= 16'h0082);
    assign exp_done = run && (since_reg[4:0] == 5'h02);
    assign exp_busy = (since_reg != 16'h0000) && (scan_reg || since_reg <= 16'h0081);
    assign exp_cnt  = (since_reg < 16'h0022) ? 3'h0 :
                      (since_reg >= 16'h0082) ? 3'h4 : 3'((since_reg - 16'h0002) >> 5);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_start; cmd_wr_i |=> busy_o && done_count_o == 3'h0 && !conv_done_o; endproperty
    a_start: assert property (p_start) else $error("start timing off");
    property p_busy; busy_o == exp_busy; endproperty
    a_busy: assert property (p_busy) else $error("busy level off");
    property p_done; conv_done_o == exp_done; endproperty
    a_done: assert property (p_done) else $error("result spacing off");
    property p_pulse; conv_done_o |=> !conv_done_o [*8]; endproperty
    a_pulse: assert property (p_pulse) else $error("done pulse too long");
    property p_count; done_count_o == exp_cnt; endproperty
    a_count: assert property (p_count) else $error("done count off");
    property p_scan; scan_reg && since_reg > 16'h0082 |-> busy_o && done_count_o == 3'h4; endproperty
    a_scan: assert property (p_scan) else $error("scan stopped");
    property p_halt; !scan_reg && since_reg > 16'h0082 |-> !busy_o && !conv_done_o; endproperty
    a_halt: assert property (p_halt) else $error("activity after fourth result");
    property p_hold; !$stable(rd_data_o) |-> $past(conv_done_o, 2) || $past(rd_slot_i) != $past(rd_slot_i, 2); endproperty
    a_hold: assert property (p_hold) else $error("result changed without cause");
endmodule // adcsq_seq_monitor

bind adcsq_seq adcsq_seq_monitor i_mon (.core_clk_i, .rst_b_i, .cmd_wr_i, .cmd_i, .rd_slot_i,
    .rd_data_o, .busy_o, .done_count_o, .conv_done_o);

// *** verification/testbench.sv ***
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: References at full scale and zero except in the reference test, so an input code converts to itself.
// Notes:   Each command queues its expected codes; the reader pops one per result.
`timescale 1ns/10ps
`include "adcsq_defs.svh"
module testbench
    import adcsq_pkg::*;
;
    logic            core_clk_i  = 1'b0;
    logic            rst_b_i     = 1'b0;
    logic            cmd_wr_i    = 1'b0;
    adcsq_cmd_t      cmd_i       = '0;
    logic [7:0][7:0] analog_in_i = '0;
    logic [7:0]      ref_high_i  = `ADCSQ_CODE_FULL;
    logic [7:0]      ref_low_i   = `ADCSQ_CODE_ZERO;
    logic [1:0]      rd_slot_i   = 2'h0;
    logic [7:0]      rd_data_o;
    logic            busy_o;
    logic            conv_done_o;
    logic [2:0]      done_count_o;
    logic [7:0]      exp_q[$];
    logic [7:0][7:0] nv;
    integer          seed        = 59;
    integer          n_mismatch  = 0;
    integer          tests_run   = 0;
    integer          cyc         = 0;
    always #2 core_clk_i = ~core_clk_i;
    adcsq_seq i_dut (.core_clk_i, .rst_b_i, .cmd_wr_i, .cmd_i, .analog_in_i, .ref_high_i,
        .ref_low_i, .rd_slot_i, .rd_data_o, .busy_o, .done_count_o, .conv_done_o);
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Writes a command with fresh random input levels and queues n expected codes.
    task automatic send(input logic [3:0] ch, input logic sc, input int n);
        logic [7:0] e;
        for (int i = 0; i < 8; i++)
            nv[i] = 8'($random(seed));
        e = (ch <= `ADCSQ_CH_LAST_INPUT) ? nv[ch[2:0]] : (ch == `ADCSQ_CH_REF_HIGH) ? `ADCSQ_CODE_FULL :
            (ch == `ADCSQ_CH_REF_HALF) ? (`ADCSQ_CODE_FULL >> 1) : `ADCSQ_CODE_ZERO;
        repeat (n) exp_q.push_back(e);
        analog_in_i <= nv;
        cmd_i       <= '{channel: ch, scan: sc};
        cmd_wr_i    <= 1'b1;
        rd_slot_i   <= 2'h0;
        @(posedge core_clk_i);
    endtask
    task automatic idle(input int n);
        cmd_wr_i <= 1'b0;
        repeat (n) @(posedge core_clk_i);
    endtask
    // Reads each finished slot once its data lands, then points at the next slot.
    always @(negedge core_clk_i) begin
        if (rst_b_i && conv_done_o === 1'b1) begin
            @(negedge core_clk_i);
            @(negedge core_clk_i);
            if (exp_q.size() == 0)
                check("spare result", 8'h00, 8'h01);
            else
                check("result", exp_q.pop_front(), rd_data_o);
            @(posedge core_clk_i);
            rd_slot_i <= rd_slot_i + 2'h1;
        end
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(posedge core_clk_i);
        for (int ch = 0; ch < 16; ch++) begin
            send(4'(ch), 1'b0, 4);
            idle(140);
        end
        $display("channel sweep ended");
        ref_high_i <= 8'hC0;
        ref_low_i  <= 8'h40;
        send(`ADCSQ_CH_REF_HIGH, 1'b0, 4);
        idle(140);
        send(`ADCSQ_CH_REF_LOW, 1'b0, 4);
        idle(140);
        $display("reference test ended");
        ref_high_i <= `ADCSQ_CODE_FULL;
        ref_low_i  <= `ADCSQ_CODE_ZERO;
        send(4'h3, 1'b1, 6);
        idle(205);
        send(4'h5, 1'b0, 0);
        send(4'h6, 1'b0, 4);
        idle(140);
        $display("scan and restart ended");
        check("pending", 8'h00, 8'(exp_q.size()));
        test_done();
    end
endmodule // testbench
